// file: clkgen_events.sv
/*
  Loss-of-lock and loss-of-clock event handling: sticky flag or reset
  request.
  Assumes: event inputs are synchronous levels to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module clkgen_events
  import clkgen_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic lock_loss,
  input  wire logic clock_loss,
  input  wire logic loss_det_en,
  input  wire logic lock_rst_sel,
  input  wire logic clock_rst_sel,
  input  wire logic flag_clear,
  output logic      flag_q,
  output logic      reset_req_q
);

  typedef struct packed {
    logic lock_prev;
    logic clk_prev;
    logic flag;
    logic rreq;
  } ev_state_s;

  ev_state_s s_q;
  ev_state_s s_d;
  logic      lock_ev;
  logic      clk_ev;

  // ****************************************************************
  // Event routing, set wins over clear
  // ****************************************************************
  always_comb
  begin
    lock_ev       = lock_loss & ~s_q.lock_prev;
    clk_ev        = clock_loss & ~s_q.clk_prev & loss_det_en;
    s_d           = s_q;
    s_d.lock_prev = lock_loss;
    s_d.clk_prev  = clock_loss;
    s_d.rreq      = (lock_ev & lock_rst_sel) | (clk_ev & clock_rst_sel);
    if (flag_clear)
      s_d.flag = 1'b0;
    if ((lock_ev && !lock_rst_sel) || (clk_ev && !clock_rst_sel))
      s_d.flag = 1'b1;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign flag_q      = s_q.flag;
  assign reset_req_q = s_q.rreq;

  // Interrupt choice on loss of lock
  lock_irq_a: assert property (@(posedge clk) disable iff (rst)
    (lock_loss && !s_q.lock_prev && !lock_rst_sel) |=> (flag_q && !reset_req_q))
    else $error("lock loss did not raise flag");

  // Interrupt choice on loss of clock
  clk_irq_a: assert property (@(posedge clk) disable iff (rst)
    (clk_ev && !clock_rst_sel) |=> (flag_q && !reset_req_q))
    else $error("clock loss did not raise flag");

  // Flag holds until cleared
  flag_hold_a: assert property (@(posedge clk) disable iff (rst)
    (flag_q && !flag_clear) |=> flag_q)
    else $error("flag dropped without clear");

endmodule : clkgen_events
`default_nettype wire

// file: clkgen_loop_model.sv
/*
  Model of the reference source and loop monitor that face the block:
  reference start-up, oscillator settling and loss events.
  Assumes: the bench commands it synchronously to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module clkgen_loop_model
  import clkgen_pkg::*;
(
  input  wire logic    clk,
  input  wire logic    rst,
  input  wire logic    slow,
  input  wire logic    ext_on,
  input  wire logic    stable_on,
  input  wire logic    lose_lock,
  input  wire logic    lose_clk,
  output var loop_status_s loop_status
);
  logic [3:0] ext_cnt_q;
  logic [3:0] stb_cnt_q;
  logic [3:0] lim;

  // ****************************************************************
  // Start-up delays
  // ****************************************************************
  // Slow case stands for a crystal that takes a while to start
  assign lim = slow ? 4'h8 : 4'h1;

  // Status is registered so events arrive a cycle after the command
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ext_cnt_q   <= 4'h0;
      stb_cnt_q   <= 4'h0;
      loop_status <= '0;
    end
    else
    begin
      ext_cnt_q <= !ext_on ? 4'h0 : (ext_cnt_q < lim) ? ext_cnt_q + 4'h1 : ext_cnt_q;
      stb_cnt_q <= !stable_on ? 4'h0 : (stb_cnt_q < lim) ? stb_cnt_q + 4'h1 : stb_cnt_q;
      loop_status.ext_in_use <= ext_on && (ext_cnt_q == lim);
      loop_status.osc_stable <= stable_on && (stb_cnt_q == lim);
      loop_status.lock_loss  <= lose_lock;
      loop_status.clock_loss <= lose_clk;
      loop_status.locked     <= !lose_lock;
    end
  end
endmodule : clkgen_loop_model
`default_nettype wire

// file: clkgen_pkg.sv
/*
  Constants, field layouts and carrier types for the clock generator
  configuration block.
  Assumes: one 100 MHz clock, register port with one-cycle read latency.
*/
package clkgen_pkg;

  // ****************************************************************
  // Register offsets (indices on the plain register port)
  // ****************************************************************
  localparam logic [2:0] OFS_MODE_CTRL   = 3'h0;
  localparam logic [2:0] OFS_LOOP_CTRL   = 3'h1;
  localparam logic [2:0] OFS_STATUS_ONE  = 3'h2;
  localparam logic [2:0] OFS_STATUS_TWO  = 3'h3;
  localparam logic [2:0] OFS_TRIM        = 3'h4;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_HIGH_GAIN    = 7;
  localparam int BIT_RANGE        = 6;
  localparam int BIT_EXT_REF_SEL  = 5;
  localparam int MODE_HI          = 4;
  localparam int MODE_LO          = 3;
  localparam int BIT_OSC_KEEP     = 2;
  localparam int BIT_LOSS_DIS     = 1;
  localparam int BIT_LOCK_RST     = 7;
  localparam int MULT_HI          = 6;
  localparam int MULT_LO          = 4;
  localparam int BIT_CLOCK_RST    = 3;
  localparam int DIV_HI           = 2;
  localparam int DIV_LO           = 0;
  // Status one: flag in bit 0, in-use bit 1, loss-of-clock 2, lock 3,
  // loss-of-lock 4
  localparam int ST_FLAG          = 0;
  localparam int ST_EXT_IN_USE    = 1;
  localparam int ST_CLK_LOSS      = 2;
  localparam int ST_LOCKED        = 3;
  localparam int ST_LOCK_LOSS     = 4;
  localparam int ST_STABLE        = 0;

  // ****************************************************************
  // Reset values and prescale factors
  // ****************************************************************
  localparam logic [7:0] MODE_CTRL_RST = 8'h00;
  localparam logic [7:0] LOOP_CTRL_RST = 8'h00;
  localparam logic [7:0] TRIM_RST      = 8'h80;
  localparam logic [7:0] PRESCALE_HIGH = 8'h01;
  localparam logic [7:0] PRESCALE_LOW  = 8'h40;
  localparam logic [3:0] INT_REF_DIV   = 4'h7;
  localparam logic [4:0] MULT_BASE     = 5'h04;

  // Nominal frequencies in MHz, self-clocked output and its bus clock
  localparam int SCM_OUT_MHZ = 8;
  localparam int SCM_BUS_MHZ = 4;
  // Cycles a mode or multiplier change stays pending
  localparam int SETTLE_NS   = 200;
  localparam int CLK_NS      = 10;
  localparam int SETTLE_CYC  = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_SELF     = 2'b00,
    MODE_ENG_INT  = 2'b01,
    MODE_BYP_EXT  = 2'b10,
    MODE_ENG_EXT  = 2'b11
  } clock_mode_e;

  // Clock configuration that leaves the block toward the analog parts
  typedef struct packed {
    clock_mode_e mode;
    logic [7:0]  prescale;
    logic [4:0]  multiplier;
    logic [7:0]  divisor;
    logic        ref_div7;
    logic        high_gain;
    logic        high_range;
    logic        crystal_req;
    logic        osc_enable;
    logic        loss_det_en;
    logic [7:0]  trim;
  } clock_cfg_s;

  // Loss events and status from the loop and the reference monitor
  typedef struct packed {
    logic lock_loss;
    logic clock_loss;
    logic locked;
    logic ext_in_use;
    logic osc_stable;
  } loop_status_s;

  // Multiplier code to N
  function automatic logic [4:0] mult_of(input logic [2:0] code);
    mult_of = MULT_BASE + {1'b0, code, 1'b0};
  endfunction : mult_of

  // Divisor code to R
  function automatic logic [7:0] div_of(input logic [2:0] code);
    div_of = 8'h01 << code;
  endfunction : div_of

endpackage : clkgen_pkg

// file: clkgen_regs.sv
/*
  Register file of the clock generator: control, loop and trim registers
  with write-once bits.
  Assumes: write strobe is a one-cycle pulse, synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module clkgen_regs
  import clkgen_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       wr_mode,
  input  wire logic       wr_loop,
  input  wire logic       wr_trim,
  input  wire logic [7:0] wdata,
  input  wire logic       busy,
  output logic      [7:0] mode_ctrl_q,
  output logic      [7:0] loop_ctrl_q,
  output logic      [7:0] trim_q,
  output logic            change_q
);

  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] loop;
    logic [7:0] trim;
    logic       once;
    logic       ext_locked_out;
    logic       change;
  } reg_state_s;

  reg_state_s s_q;
  reg_state_s s_d;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb
  begin
    s_d        = s_q;
    s_d.change = 1'b0;
    if (wr_mode)
    begin
      s_d.mode[BIT_HIGH_GAIN] = wdata[BIT_HIGH_GAIN];
      s_d.mode[BIT_OSC_KEEP]  = wdata[BIT_OSC_KEEP];
      s_d.mode[BIT_LOSS_DIS]  = wdata[BIT_LOSS_DIS];
      // Range and reference select take the first write only
      if (!s_q.once)
      begin
        s_d.mode[BIT_RANGE]       = wdata[BIT_RANGE];
        s_d.mode[BIT_EXT_REF_SEL] = wdata[BIT_EXT_REF_SEL];
        s_d.once                  = 1'b1;
        s_d.ext_locked_out        = ~wdata[MODE_HI];
      end
      // Mode field ignored while a change settles; no external pin after a first write of 0X
      if (!busy && !(s_q.ext_locked_out && wdata[MODE_HI]))
      begin
        s_d.mode[MODE_HI:MODE_LO] = wdata[MODE_HI:MODE_LO];
        s_d.change                = 1'b1;
      end
      s_d.mode[0] = 1'b0;
    end
    if (wr_loop)
    begin
      s_d.loop[BIT_LOCK_RST]    = wdata[BIT_LOCK_RST];
      s_d.loop[BIT_CLOCK_RST]   = wdata[BIT_CLOCK_RST];
      s_d.loop[DIV_HI:DIV_LO]   = wdata[DIV_HI:DIV_LO];
      if (!busy)
      begin
        s_d.loop[MULT_HI:MULT_LO] = wdata[MULT_HI:MULT_LO];
        s_d.change                = 1'b1;
      end
    end
    if (wr_trim)
      s_d.trim = wdata;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      s_q <= '{mode: MODE_CTRL_RST, loop: LOOP_CTRL_RST, trim: TRIM_RST,
               once: 1'b0, ext_locked_out: 1'b0, change: 1'b0};
    else
      s_q <= s_d;
  end

  assign mode_ctrl_q = s_q.mode;
  assign loop_ctrl_q = s_q.loop;
  assign trim_q      = s_q.trim;
  assign change_q    = s_q.change;

  // Range bit holds after the first write
  range_once_a: assert property (@(posedge clk) disable iff (rst)
    (s_q.once && wr_mode) |=> $stable(s_q.mode[BIT_RANGE]))
    else $error("range bit changed after first write");

  // Mode field frozen while busy
  mode_hold_a: assert property (@(posedge clk) disable iff (rst)
    (busy && s_q.once && wr_mode) |=> $stable(s_q.mode[MODE_HI:MODE_LO]))
    else $error("mode field changed while pending");

  // Bit zero never set
  bit_zero_a: assert property (@(posedge clk) disable iff (rst)
    s_q.mode[0] == 1'b0)
    else $error("reserved bit set");

endmodule : clkgen_regs
`default_nettype wire

// file: clock_generator.sv
/*
  Configuration and mode logic of the on-chip clock generator: register
  port, mode selection, loop factors and event responses.
  Assumes: register port strobes are single-cycle and never together;
  loop status inputs are synchronous to clk.
*/
// Notes on behaviour
// - After reset runs self-clocked, about 8 MHz out, 4 MHz bus.
// - Engaged external: out equals reference times P times N over R.
// - Engaged internal: out equals internal reference over 7, times 64, N, over R.
// - Outside engaged internal, range bit set gives P of 1, clear gives P of 64.
// - Mode code 11 engaged external, 01 engaged internal.
// - Multiplier field sets N; code 011 gives 10.
// - Divisor field sets R; 000 divides by 1, 001 by 2.
// - Lock-loss reset bit clear raises interrupt, not reset.
// - Clock-loss reset bit clear raises interrupt, not reset.
// - Oscillator-keep bit clear turns oscillator off in stop.
// - High-gain bit clear selects low-power oscillator operation.
// - Reference select requests crystal; no effect in engaged internal.
// - Control one bit 0 always reads zero.
// - Status one read-only except clearing the interrupt flag.
// - Status two read-only, reports oscillator stable; software checks it.
// - Trim register adjusts the internal reference oscillator.
// - Range and reference select accept only the first write after reset.
// - Bypassed external mode waits until external reference is in use.
// - Code 00 self-clocked; mode or multiplier writes ignored while pending.
`timescale 1ns/1ps
`default_nettype none
module clock_generator
  import clkgen_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [2:0]   addr,
  input  wire logic [7:0]   wdata,
  input  wire logic         wr,
  input  wire logic         rd,
  output logic      [7:0]   rdata,
  input  wire loop_status_s loop_status,
  input  wire logic         stop_mode,
  output var clock_cfg_s    cfg,
  output logic              irq,
  output logic              reset_req
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 255)
  begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end

  // All top-level state in one register
  typedef struct packed {
    logic [7:0] rdata;
    clock_cfg_s cfg;
    logic [7:0] pend;
    logic       irq;
    logic       rreq;
  } top_state_s;

  top_state_s s_q;
  top_state_s s_d;

  // Links between decode and sub-blocks
  logic [7:0] mode_ctrl;
  logic [7:0] loop_ctrl;
  logic [7:0] trim;
  logic       change;
  logic       flag;
  logic       rreq_ev;
  logic       busy;
  logic       wr_mode;
  logic       wr_loop;
  logic       wr_trim;
  logic       clr_flag;
  clock_mode_e req_mode;

  // ****************************************************************
  // Write decode
  // ****************************************************************
  always_comb
  begin
    wr_mode  = 1'b0;
    wr_loop  = 1'b0;
    wr_trim  = 1'b0;
    clr_flag = 1'b0;
    if (wr && addr == OFS_MODE_CTRL)
      wr_mode = 1'b1;
    else if (wr && addr == OFS_LOOP_CTRL)
      wr_loop = 1'b1;
    else if (wr && addr == OFS_TRIM)
      wr_trim = 1'b1;
    else if (wr && addr == OFS_STATUS_ONE)
      clr_flag = wdata[ST_FLAG];
  end

  // Taken write blocks the next cycle too
  assign busy = change || (s_q.pend != 8'h00);

  // Write-once and pending rules
  clkgen_regs u_regs (
    .clk         (clk),
    .rst         (rst),
    .wr_mode     (wr_mode),
    .wr_loop     (wr_loop),
    .wr_trim     (wr_trim),
    .wdata       (wdata),
    .busy        (busy),
    .mode_ctrl_q (mode_ctrl),
    .loop_ctrl_q (loop_ctrl),
    .trim_q      (trim),
    .change_q    (change)
  );

  // Sticky flag or reset pulse
  clkgen_events u_events (
    .clk           (clk),
    .rst           (rst),
    .lock_loss     (loop_status.lock_loss),
    .clock_loss    (loop_status.clock_loss),
    .loss_det_en   (~mode_ctrl[BIT_LOSS_DIS]),
    .lock_rst_sel  (loop_ctrl[BIT_LOCK_RST]),
    .clock_rst_sel (loop_ctrl[BIT_CLOCK_RST]),
    .flag_clear    (clr_flag),
    .flag_q        (flag),
    .reset_req_q   (rreq_ev)
  );

  // Mode as asked, before bypass wait
  assign req_mode = clock_mode_e'(mode_ctrl[MODE_HI:MODE_LO]);

  // ****************************************************************
  // Configuration, pending timer and read mux
  // ****************************************************************
  always_comb
  begin
    s_d      = s_q;
    // Flag and reset request registered once
    s_d.irq  = flag;
    s_d.rreq = rreq_ev;
    // A mode or multiplier change stays pending for a settle time
    if (change)
      s_d.pend = 8'(SETTLE_CYCLES);
    else if (s_q.pend != 8'h00)
      s_d.pend = s_q.pend - 8'h01;
    // Bypassed external waits for the external reference
    if (req_mode == MODE_BYP_EXT && !loop_status.ext_in_use)
      s_d.cfg.mode = s_q.cfg.mode;
    else
      s_d.cfg.mode = req_mode;

    // Range and prescale
    s_d.cfg.high_range = mode_ctrl[BIT_RANGE];
    // Engaged internal always uses P of 64 and the divide by 7
    if (s_d.cfg.mode == MODE_ENG_INT)
      s_d.cfg.prescale = PRESCALE_LOW;
    else
      s_d.cfg.prescale = mode_ctrl[BIT_RANGE] ? PRESCALE_HIGH : PRESCALE_LOW;
    s_d.cfg.ref_div7    = (s_d.cfg.mode == MODE_ENG_INT);

    // Factors and oscillator controls
    s_d.cfg.multiplier  = mult_of(loop_ctrl[MULT_HI:MULT_LO]);
    s_d.cfg.divisor     = div_of(loop_ctrl[DIV_HI:DIV_LO]);
    s_d.cfg.high_gain   = mode_ctrl[BIT_HIGH_GAIN];
    s_d.cfg.crystal_req = mode_ctrl[BIT_EXT_REF_SEL] && (s_d.cfg.mode != MODE_ENG_INT);
    s_d.cfg.osc_enable  = !stop_mode || mode_ctrl[BIT_OSC_KEEP];
    s_d.cfg.loss_det_en = ~mode_ctrl[BIT_LOSS_DIS];
    s_d.cfg.trim        = trim;

    // Read data valid in the cycle after the strobe only
    s_d.rdata = 8'h00;
    if (rd && addr == OFS_MODE_CTRL)
      s_d.rdata = {mode_ctrl[7:1], 1'b0};
    else if (rd && addr == OFS_LOOP_CTRL)
      s_d.rdata = loop_ctrl;
    else if (rd && addr == OFS_STATUS_ONE)
    begin
      s_d.rdata[ST_FLAG]       = flag;
      s_d.rdata[ST_EXT_IN_USE] = loop_status.ext_in_use;
      s_d.rdata[ST_CLK_LOSS]   = loop_status.clock_loss;
      s_d.rdata[ST_LOCKED]     = loop_status.locked;
      s_d.rdata[ST_LOCK_LOSS]  = loop_status.lock_loss;
    end
    else if (rd && addr == OFS_STATUS_TWO)
      s_d.rdata[ST_STABLE] = loop_status.osc_stable;
    else if (rd && addr == OFS_TRIM)
      s_d.rdata = trim;
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q          <= '0;
      s_q.cfg.mode <= MODE_SELF;
      s_q.cfg.prescale   <= PRESCALE_LOW;
      s_q.cfg.multiplier <= MULT_BASE;
      s_q.cfg.divisor    <= 8'h01;
      s_q.cfg.osc_enable <= 1'b1;
      s_q.cfg.loss_det_en <= 1'b1;
      s_q.cfg.trim       <= TRIM_RST;
    end
    else
      s_q <= s_d;
  end

  // Outputs straight from the register
  assign rdata     = s_q.rdata;
  assign cfg       = s_q.cfg;
  assign irq       = s_q.irq;
  assign reset_req = s_q.rreq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence ext_write_s;
    wr_mode && !busy && wdata[MODE_HI:MODE_LO] == MODE_ENG_EXT;
  endsequence

  sequence ext_taken_s;
    req_mode == MODE_ENG_EXT && mode_ctrl[BIT_RANGE];
  endsequence

  // Range decides P
  prescale_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.mode != MODE_ENG_INT) |-> (cfg.prescale == (cfg.high_range ? PRESCALE_HIGH : PRESCALE_LOW)))
    else $error("wrong prescale for range");

  // Internal: P 64, divide by 7
  int_mode_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.mode == MODE_ENG_INT) |-> (cfg.prescale == PRESCALE_LOW && cfg.ref_div7 && !cfg.crystal_req))
    else $error("internal mode factors wrong");

  // Bypass waits for reference
  bypass_wait_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.mode == MODE_BYP_EXT && !$past(cfg.mode == MODE_BYP_EXT)) |-> $past(loop_status.ext_in_use))
    else $error("bypass entered without external reference");

  // Oscillator off in stop
  osc_stop_a: assert property (@(posedge clk) disable iff (rst)
    (stop_mode && !mode_ctrl[BIT_OSC_KEEP]) |=> !cfg.osc_enable)
    else $error("oscillator left on in stop");

  // Stable flag on read
  stable_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFS_STATUS_TWO) |=> (rdata == {7'h00, $past(loop_status.osc_stable)}))
    else $error("stable flag read wrong");

  // Irq trails the flag
  irq_follow_a: assert property (@(posedge clk) disable iff (rst)
    flag |=> irq)
    else $error("irq does not follow flag");

  // External engage, high range
  ext_engage_a: assert property (@(posedge clk) disable iff (rst)
    ext_write_s ##1 ext_taken_s |=> (cfg.mode == MODE_ENG_EXT && cfg.prescale == PRESCALE_HIGH))
    else $error("external mode not engaged");

  // N steps by two
  mult_table_a: assert property (@(posedge clk) disable iff (rst)
    !rst |=> (cfg.multiplier == MULT_BASE + 5'(2 * $past(loop_ctrl[MULT_HI:MULT_LO]))))
    else $error("multiplier wrong");

  // R doubles per step
  div_table_a: assert property (@(posedge clk) disable iff (rst)
    !rst |=> (cfg.divisor == 8'(8'h01 << $past(loop_ctrl[DIV_HI:DIV_LO]))))
    else $error("divisor wrong");

  // Gain follows its bit
  gain_follow_a: assert property (@(posedge clk) disable iff (rst)
    !rst |=> (cfg.high_gain == $past(mode_ctrl[BIT_HIGH_GAIN])))
    else $error("gain wrong");

  // No crystal in internal
  crystal_req_a: assert property (@(posedge clk) disable iff (rst)
    !rst |=> (cfg.crystal_req == ($past(mode_ctrl[BIT_EXT_REF_SEL]) && cfg.mode != MODE_ENG_INT)))
    else $error("crystal request wrong");

  // Trim reaches oscillator
  trim_follow_a: assert property (@(posedge clk) disable iff (rst)
    !rst |=> (cfg.trim == $past(trim)))
    else $error("trim wrong");

  // Bit zero reads zero
  mode_read_a: assert property (@(posedge clk) disable iff (rst)
    (rd && addr == OFS_MODE_CTRL) |=> !rdata[0])
    else $error("bit zero read set");

endmodule : clock_generator
`default_nettype wire

// file: clock_generator_tb_top.sv
/*
  Self-checking bench for the clock generator configuration block.
  Assumes: the loop model stands in for the analog parts.
*/
`timescale 1ns/1ps
`default_nettype none
module clock_generator_tb_top;
  import clkgen_pkg::*;

  logic         clk;
  logic         rst;
  logic [2:0]   addr;
  logic [7:0]   wdata;
  logic         wr;
  logic         rd;
  logic [7:0]   rdata;
  loop_status_s loop_status;
  logic         stop_mode;
  clock_cfg_s   cfg;
  logic         irq;
  logic         reset_req;
  logic         slow;
  logic         ext_on;
  logic         stable_on;
  logic         lose_lock;
  logic         lose_clk;
  int           error_cnt = 0;
  int           n_tests = 0;
  int           rr_cnt = 0;
  int           cyc = 0;

  // Short settle keeps the run brief; waits below allow for it
  clock_generator #(.SETTLE_CYCLES(4)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .loop_status(loop_status), .stop_mode(stop_mode),
    .cfg(cfg), .irq(irq), .reset_req(reset_req));

  clkgen_loop_model model_u (.clk(clk), .rst(rst), .slow(slow), .ext_on(ext_on),
    .stable_on(stable_on), .lose_lock(lose_lock), .lose_clk(lose_clk), .loop_status(loop_status));

  // ****************************************************************
  // Clock, pulse counter and hang guard
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Reset requests are one-cycle pulses, so count them as they pass
  always @(posedge clk)
  begin
    cyc++;
    if (reset_req === 1'b1)
      rr_cnt++;
    if (cyc == 3000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(nm, e, rdata & m);
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  // One-cycle loss event, then time for flag and irq to follow
  task automatic pulse(input logic lock);
    @(posedge clk);
    if (lock)
      lose_lock <= 1'b1;
    else
      lose_clk <= 1'b1;
    @(posedge clk);
    lose_lock <= 1'b0;
    lose_clk  <= 1'b0;
    idle(5);
  endtask : pulse

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    {addr, wdata, wr, rd, stop_mode, slow, ext_on, stable_on, lose_lock, lose_clk} = '0;
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    idle(1);
    check("mode", {6'h0, MODE_SELF}, {6'h0, cfg.mode});
    check("prescale", 8'h40, cfg.prescale);
    check("mult", 8'h04, {3'h0, cfg.multiplier});
    check("div", 8'h01, cfg.divisor);
    rd_chk(OFS_TRIM, 8'hff, 8'h80, "trim");
    wr_reg(OFS_MODE_CTRL, 8'h79);
    rd_chk(OFS_MODE_CTRL, 8'hff, 8'h78, "ctrl_one");
    idle(8);
    check("mode", {6'h0, MODE_ENG_EXT}, {6'h0, cfg.mode});
    check("prescale", 8'h01, cfg.prescale);
    check("flags", 8'h05, {4'h0, cfg.high_gain, cfg.high_range, cfg.ref_div7, cfg.crystal_req});
    @(posedge clk) stop_mode <= 1'b1;
    idle(3);
    check("osc_en", 8'h00, {7'h0, cfg.osc_enable});
    @(posedge clk) stop_mode <= 1'b0;
    // Every multiplier and divisor code
    for (int i = 0; i < 8; i++)
    begin
      wr_reg(OFS_LOOP_CTRL, {1'b0, i[2:0], 1'b0, i[2:0]});
      idle(8);
      check("mult", 8'(4 + 2 * i), {3'h0, cfg.multiplier});
      check("div", 8'h01 << i, cfg.divisor);
    end
    // Second mode write follows with no gap and is refused
    @(posedge clk) {addr, wdata, wr} <= {OFS_MODE_CTRL, 8'h08, 1'b1};
    @(posedge clk) wdata <= 8'h18;
    @(posedge clk) wr <= 1'b0;
    idle(8);
    check("mode", {6'h0, MODE_ENG_INT}, {6'h0, cfg.mode});
    check("flags", 8'h03, {5'h0, cfg.high_gain, cfg.high_range, cfg.ref_div7});
    check("prescale", 8'h40, cfg.prescale);
    wr_reg(OFS_MODE_CTRL, 8'hf4);
    idle(8);
    check("mode", {6'h0, MODE_ENG_INT}, {6'h0, cfg.mode});
    check("high_gain", 8'h01, {7'h0, cfg.high_gain});
    @(posedge clk) slow <= 1'b1;
    @(posedge clk) ext_on <= 1'b1;
    idle(14);
    check("mode", {6'h0, MODE_BYP_EXT}, {6'h0, cfg.mode});
    rd_chk(OFS_STATUS_ONE, 8'h02, 8'h02, "in_use");
    @(posedge clk) stop_mode <= 1'b1;
    idle(3);
    check("osc_en", 8'h01, {7'h0, cfg.osc_enable});
    @(posedge clk) stable_on <= 1'b1;
    idle(12);
    rd_chk(OFS_STATUS_TWO, 8'h01, 8'h01, "stable");
    wr_reg(OFS_STATUS_TWO, 8'h00);
    rd_chk(OFS_STATUS_TWO, 8'h01, 8'h01, "stable");
    rd_chk(3'h5, 8'hff, 8'h00, "unmapped");
    // Trim under a doubled divisor, then restore it
    wr_reg(OFS_LOOP_CTRL, 8'h31);
    idle(8);
    check("div", 8'h02, cfg.divisor);
    wr_reg(OFS_TRIM, 8'h5a);
    rd_chk(OFS_TRIM, 8'hff, 8'h5a, "trim");
    check("cfg_trim", 8'h5a, cfg.trim);
    wr_reg(OFS_LOOP_CTRL, 8'h30);
    idle(8);
    check("mult", 8'h0a, {3'h0, cfg.multiplier});
    check("div", 8'h01, cfg.divisor);
    // Loss events with the interrupt response
    pulse(1'b1);
    check("irq", 8'h01, {7'h0, irq});
    rd_chk(OFS_STATUS_ONE, 8'h01, 8'h01, "flag");
    wr_reg(OFS_STATUS_ONE, 8'hfe);
    idle(3);
    check("irq", 8'h01, {7'h0, irq});
    wr_reg(OFS_STATUS_ONE, 8'h01);
    idle(3);
    check("irq", 8'h00, {7'h0, irq});
    pulse(1'b0);
    check("irq", 8'h01, {7'h0, irq});
    wr_reg(OFS_STATUS_ONE, 8'h01);
    idle(3);
    // Same events with the reset response
    wr_reg(OFS_LOOP_CTRL, 8'hb8);
    idle(8);
    pulse(1'b1);
    pulse(1'b0);
    check("reset_reqs", 8'h02, rr_cnt[7:0]);
    check("irq", 8'h00, {7'h0, irq});
    wr_reg(OFS_MODE_CTRL, 8'hf6);
    pulse(1'b0);
    check("loss_en", 8'h00, {7'h0, cfg.loss_det_en});
    check("reset_reqs", 8'h02, rr_cnt[7:0]);
    give_verdict();
  end
endmodule : clock_generator_tb_top
`default_nettype wire
